// >>> hdl/serial_receiver.sv
// serial receiver with address detect and wake-up on break
`timescale 1ns/1ps
// Behaviour
// - recover bits with x16 oversampler feeding the bit shifter
// - invert serial input when receive_polarity_invert set
// - asynchronous operation only when sync clear and port enabled
// - nine-bit mode stores ninth bit in status register
// - accept characters only while continuous receive enable is set
// - set receive-complete flag per character; irq only if enabled
// - framing and overrun reported; cleared by clearing receive enable
// - low eight bits readable in receive data register
// - address detect in nine-bit mode withholds data characters from buffer and flag
// - irq acknowledged only with local and global enable; priority selects level
// - asleep, clocks stop; no reception possible
// - wake-up only in asynchronous mode, on receive line activity
// - wake enable suspends reception and watches for wake event
// - falling edge with wake enable sets receive-complete flag
// - wake irq synchronous awake, asynchronous while asleep
// - reading receive data clears pending wake interrupt
// - wake enable auto-clears on next rising edge after wake event
// - frame is start, eight or nine data bits LSB first, one stop
// - generator gives x16 or x64 sample clock by mode bits
module serial_receiver
  import rx_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic serial_input_pin,
  input wire logic sleep_mode,
  output logic irq_high,
  output logic irq_low,
  output logic wake_request
);
  import rx_pkg::*;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] stat_r;
  logic [7:0] data_r;
  logic [7:0] txs_r;
  logic [7:0] baud_r;
  logic [7:0] div_hi_r;
  logic [7:0] div_lo_r;
  logic [2:0] irqc_r;
  logic flag_r;
  logic full_r;
  logic wake_seen_r;
  logic pin_s1_r;
  logic pin_s2_r;
  logic line_prev_r;
  logic line;
  logic async_on;
  logic run;
  logic rd_data;
  logic wr_stat;
  logic wr_baud;
  logic clr_err;

  // strobe qualified by a register index
  function automatic logic hit(input logic stb, input logic [2:0] idx, input logic [2:0] at);
    hit = stb && (idx == at);
  endfunction

  assign rd_data = hit(reg_rd, reg_addr, ADDR_RCV_DATA);
  assign wr_stat = hit(reg_wr, reg_addr, ADDR_RCV_STAT);
  assign wr_baud = hit(reg_wr, reg_addr, ADDR_BAUD_CTRL);
  // errors drop while continuous receive is off or being turned off
  assign clr_err = !stat_r[RS_CONT] || (wr_stat && !reg_wdata[RS_CONT]);
  // async mode requires sync clear and port enabled
  assign async_on = stat_r[RS_PORT_EN] && !txs_r[TS_SYNC];
  // clocks to the port stop while asleep
  assign run = async_on && !sleep_mode;

  // ----------------------------------------------------------------
  // pin synchroniser and polarity
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pin_s1_r <= 1'b1;
      pin_s2_r <= 1'b1;
    end else begin
      pin_s1_r <= serial_input_pin;
      pin_s2_r <= pin_s1_r;
    end
  end

  assign line = pin_s2_r ^ baud_r[BC_INVERT];

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      line_prev_r <= 1'b1;
    end else begin
      line_prev_r <= line;
    end
  end

  // ----------------------------------------------------------------
  // baud generator: sample tick at x16 bit rate
  // ----------------------------------------------------------------
  logic [15:0] brg_cnt_r;
  logic [1:0] pre_r;
  logic [15:0] div_val;
  logic brg_wrap;
  logic tick;
  logic x64;

  assign div_val = baud_r[BC_DIV16] ? {div_hi_r, div_lo_r} : {8'h00, div_lo_r};
  // x64 when neither high speed nor 16-bit; else x16
  assign x64 = !txs_r[TS_HIGH_SPEED] && !baud_r[BC_DIV16];
  assign brg_wrap = run && (brg_cnt_r == 16'h0000);
  assign tick = brg_wrap && (!x64 || pre_r == PRESCALE_X4);

  always_ff @(posedge clk_sys) begin
    if (sys_rst || !run) begin
      brg_cnt_r <= div_val;
      pre_r <= 2'h0;
    end else if (brg_wrap) begin
      brg_cnt_r <= div_val;
      pre_r <= pre_r + 2'h1;
    end else begin
      brg_cnt_r <= brg_cnt_r - 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // receive state machine
  // ----------------------------------------------------------------
  rx_state_t state_r;
  logic [3:0] samp_r;
  logic [3:0] bit_r;
  logic [8:0] shift_r;
  logic rx_enable;
  logic frame_done;
  logic frame_stop;
  logic [3:0] nbits;

  // wake mode idles the receiver; overrun halts it
  assign rx_enable = run && stat_r[RS_CONT] && !baud_r[BC_WAKE] && !stat_r[RS_OVERRUN_ERROR_FLAG];
  assign nbits = stat_r[RS_NINE] ? 4'h9 : 4'h8;

  always_ff @(posedge clk_sys) begin
    if (sys_rst || !rx_enable) begin
      state_r <= RX_IDLE;
      samp_r <= 4'h0;
      bit_r <= 4'h0;
      shift_r <= 9'h000;
    end else if (tick) begin
      unique case (state_r)
        RX_IDLE: begin
          samp_r <= 4'h0;
          if (!line) begin
            state_r <= RX_START;
          end
        end
        RX_START: begin
          samp_r <= samp_r + 4'h1;
          if (samp_r == MID_SAMPLE) begin
            samp_r <= 4'h0;
            bit_r <= 4'h0;
            state_r <= line ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          samp_r <= samp_r + 4'h1;
          if (samp_r == OVERSAMPLE) begin
            shift_r <= stat_r[RS_NINE] ? {line, shift_r[8:1]} : {1'b0, line, shift_r[7:1]};
            bit_r <= bit_r + 4'h1;
            if (bit_r == nbits - 4'h1) begin
              state_r <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          samp_r <= samp_r + 4'h1;
          if (samp_r == OVERSAMPLE) begin
            state_r <= RX_IDLE;
          end
        end
      endcase
    end
  end

  assign frame_done = rx_enable && tick && state_r == RX_STOP && samp_r == OVERSAMPLE;
  assign frame_stop = line;

  logic accept;
  logic store;
  // data characters dropped while address detect is on in nine-bit mode
  assign accept = !(stat_r[RS_NINE] && stat_r[RS_ADDR]) || shift_r[8];
  assign store = frame_done && accept && !full_r;

  // ----------------------------------------------------------------
  // wake-up on break
  // ----------------------------------------------------------------
  logic fall;
  logic rise;
  assign fall = line_prev_r && !line;
  assign rise = !line_prev_r && line;

  always_ff @(posedge clk_sys) begin
    if (sys_rst || !async_on || !baud_r[BC_WAKE]) begin
      wake_seen_r <= 1'b0;
    end else if (fall) begin
      wake_seen_r <= 1'b1;
    end
  end

  // asleep the request leaves without waiting for a sample tick
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wake_request <= 1'b0;
    end else begin
      wake_request <= async_on && baud_r[BC_WAKE] && fall && sleep_mode;
    end
  end

  // ----------------------------------------------------------------
  // receive data and receive-complete flag
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      data_r <= RESET_BYTE;
      full_r <= 1'b0;
    end else if (store) begin
      data_r <= shift_r[7:0];
      full_r <= 1'b1;
    end else if (rd_data) begin
      full_r <= 1'b0;
    end
  end

  // set wins over the read that clears it
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      flag_r <= 1'b0;
    end else if (store || (async_on && baud_r[BC_WAKE] && fall)) begin
      flag_r <= 1'b1;
    end else if (rd_data) begin
      flag_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // status, control and errors
  // ----------------------------------------------------------------
  // a character landing beside the clear keeps its error
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      stat_r <= RESET_BYTE;
    end else begin
      if (wr_stat) begin
        stat_r[7:3] <= reg_wdata[7:3];
      end
      if (store) begin
        stat_r[RS_BIT9] <= shift_r[8];
        stat_r[RS_FRAMING_ERROR_FLAG] <= !frame_stop;
      end else if (clr_err) begin
        stat_r[RS_FRAMING_ERROR_FLAG] <= 1'b0;
      end
      if (frame_done && accept && full_r) begin
        stat_r[RS_OVERRUN_ERROR_FLAG] <= 1'b1;
      end else if (clr_err) begin
        stat_r[RS_OVERRUN_ERROR_FLAG] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      baud_r <= RESET_BYTE;
    end else begin
      if (wr_baud) begin
        baud_r[BC_INVERT] <= reg_wdata[BC_INVERT];
        baud_r[BC_DIV16] <= reg_wdata[BC_DIV16];
      end
      baud_r[BC_IDLE] <= state_r == RX_IDLE;
      if (wake_seen_r && rise) begin
        baud_r[BC_WAKE] <= 1'b0;
      end else if (wr_baud) begin
        baud_r[BC_WAKE] <= reg_wdata[BC_WAKE];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      txs_r <= RESET_BYTE;
    end else if (hit(reg_wr, reg_addr, ADDR_TX_STAT)) begin
      txs_r[TS_SYNC] <= reg_wdata[TS_SYNC];
      txs_r[TS_HIGH_SPEED] <= reg_wdata[TS_HIGH_SPEED];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      div_hi_r <= RESET_BYTE;
    end else if (hit(reg_wr, reg_addr, ADDR_DIV_HI)) begin
      div_hi_r <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      div_lo_r <= RESET_BYTE;
    end else if (hit(reg_wr, reg_addr, ADDR_DIV_LO)) begin
      div_lo_r <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      irqc_r <= 3'h0;
    end else if (hit(reg_wr, reg_addr, ADDR_IRQ_CTRL)) begin
      irqc_r <= reg_wdata[2:0];
    end
  end

  // ----------------------------------------------------------------
  // interrupt request lines
  // ----------------------------------------------------------------
  logic irq_req;
  assign irq_req = flag_r && irqc_r[IC_ENABLE] && irqc_r[IC_GLOBAL];

  logic [7:0] irq_view;

  // interrupt control as software sees it, flag read-only
  always_comb begin
    irq_view = RESET_BYTE;
    irq_view[2:0] = irqc_r;
    irq_view[IC_FLAG] = flag_r;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      irq_high <= 1'b0;
      irq_low <= 1'b0;
    end else begin
      irq_high <= irq_req && irqc_r[IC_PRIO];
      irq_low <= irq_req && !irqc_r[IC_PRIO];
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      reg_rdata <= RESET_BYTE;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ADDR_RCV_STAT: reg_rdata <= stat_r;
        ADDR_RCV_DATA: reg_rdata <= data_r;
        ADDR_TX_STAT: reg_rdata <= txs_r;
        ADDR_BAUD_CTRL: reg_rdata <= baud_r;
        ADDR_DIV_HI: reg_rdata <= div_hi_r;
        ADDR_DIV_LO: reg_rdata <= div_lo_r;
        ADDR_IRQ_CTRL: reg_rdata <= irq_view;
        default: reg_rdata <= RESET_BYTE;
      endcase
    end else begin
      reg_rdata <= RESET_BYTE;
    end
  end
endmodule

// >>> hdl/rx_pkg.sv
// package: register map, fields and timing of the serial receiver
package rx_pkg;
  localparam logic [2:0] ADDR_RCV_STAT = 3'h0;
  localparam logic [2:0] ADDR_RCV_DATA = 3'h1;
  localparam logic [2:0] ADDR_TX_STAT = 3'h2;
  localparam logic [2:0] ADDR_BAUD_CTRL = 3'h3;
  localparam logic [2:0] ADDR_DIV_HI = 3'h4;
  localparam logic [2:0] ADDR_DIV_LO = 3'h5;
  localparam logic [2:0] ADDR_IRQ_CTRL = 3'h6;
  // receive_status_control fields
  localparam int RS_PORT_EN = 7;
  localparam int RS_NINE = 6;
  localparam int RS_CONT = 4;
  localparam int RS_ADDR = 3;
  localparam int RS_FRAMING_ERROR_FLAG = 2;
  localparam int RS_OVERRUN_ERROR_FLAG = 1;
  localparam int RS_BIT9 = 0;
  // transmit_status_control fields
  localparam int TS_SYNC = 4;
  localparam int TS_HIGH_SPEED = 2;
  // baud_control fields
  localparam int BC_IDLE = 6;
  localparam int BC_INVERT = 5;
  localparam int BC_DIV16 = 3;
  localparam int BC_WAKE = 1;
  // irq control fields
  localparam int IC_FLAG = 3;
  localparam int IC_PRIO = 2;
  localparam int IC_GLOBAL = 1;
  localparam int IC_ENABLE = 0;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [3:0] OVERSAMPLE = 4'hF;
  localparam logic [3:0] MID_SAMPLE = 4'h7;
  localparam logic [1:0] PRESCALE_X4 = 2'h3;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
endpackage

// >>> testbench/serial_receiver_checker.sv
// checker: port-level assertions for the serial receiver
`timescale 1ns/1ps
module serial_receiver_checker (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [2:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic serial_input_pin,
  input wire logic sleep_mode,
  input wire logic irq_high,
  input wire logic irq_low,
  input wire logic wake_request
);
  logic [3:0] quiet_r;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // cycles since the line last moved, saturating
  always_ff @(posedge clk_sys) begin
    if (sys_rst || $changed(serial_input_pin)) begin
      quiet_r <= 4'h0;
    end else if (quiet_r != 4'hF) begin
      quiet_r <= quiet_r + 4'h1;
    end
  end
  AST_RST_QUIET: assert property (disable iff (1'b0) sys_rst |=>
    !irq_high && !irq_low && !wake_request && reg_rdata == 8'h00) else $error("outputs busy in reset");
  AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  AST_UNMAPPED: assert property (reg_rd && reg_addr == 3'h7 |=> reg_rdata == 8'h00)
    else $error("unmapped index read nonzero");
  AST_ONE_LEVEL: assert property (!(irq_high && irq_low)) else $error("both levels");
  AST_WAKE_PULSE: assert property (wake_request |=> !wake_request)
    else $error("wake request longer than a cycle");
  AST_WAKE_ASLEEP: assert property (wake_request |-> $past(sleep_mode))
    else $error("wake request while awake");
  AST_WAKE_EDGE: assert property (wake_request |-> quiet_r < 4'h8)
    else $error("wake request without line edge");
  AST_HIGH_HOLD: assert property ($fell(irq_high) |->
    $past(reg_rd || reg_wr) || $past(reg_rd || reg_wr, 2)) else $error("high irq dropped");
  AST_LOW_HOLD: assert property ($fell(irq_low) |->
    $past(reg_rd || reg_wr) || $past(reg_rd || reg_wr, 2)) else $error("low irq dropped");
endmodule
bind serial_receiver serial_receiver_checker chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .serial_input_pin(serial_input_pin), .sleep_mode(sleep_mode), .irq_high(irq_high),
  .irq_low(irq_low), .wake_request(wake_request));

// >>> testbench/serial_line_model.sv
// partner: remote asynchronous transmitter driving the serial line
`timescale 1ns/1ps
module serial_line_model #(
  parameter int BIT_CLKS = 64
) (
  input wire logic clk_sys,
  input wire logic send,
  input wire logic [13:0] frame,
  input wire logic [3:0] count,
  output logic line,
  output logic busy
);
  logic [13:0] shift_r;
  int left_r;
  int cnt_r;
  initial begin
    line = 1'b1;
    busy = 1'b0;
  end
  // each bit held a full bit time; a zero word gives a long break
  always @(posedge clk_sys) begin
    if (send && !busy) begin
      shift_r <= frame;
      left_r <= count;
      cnt_r <= 0;
      busy <= 1'b1;
      line <= frame[0];
    end else if (busy) begin
      if (cnt_r == BIT_CLKS - 1) begin
        cnt_r <= 0;
        if (left_r == 1) begin
          busy <= 1'b0;
          line <= 1'b1;
        end else begin
          shift_r <= shift_r >> 1;
          line <= shift_r[1];
          left_r <= left_r - 1;
        end
      end else begin
        cnt_r <= cnt_r + 1;
      end
    end
  end
endmodule

// >>> testbench/test_serial_receiver.sv
// testbench: register-level tests of the serial receiver
`timescale 1ns/1ps
module test_serial_receiver;
  import rx_pkg::*;
  logic clk_sys, sys_rst, reg_wr, reg_rd, sleep_mode, send, line, busy, inv;
  logic irq_high, irq_low, wake_request;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [13:0] frame;
  logic [3:0] count;
  int failures, checks, wakes;
  serial_receiver uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .serial_input_pin(line ^ inv), .sleep_mode(sleep_mode), .irq_high(irq_high),
    .irq_low(irq_low), .wake_request(wake_request));
  serial_line_model #(.BIT_CLKS(64)) peer (.clk_sys(clk_sys), .send(send), .frame(frame),
    .count(count), .line(line), .busy(busy));
  // ---------------------------------------------
  // bus and line tasks
  // ---------------------------------------------
  task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rdc(input string name, input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    if (name != "") check(name, reg_rdata, exp);
  endtask
  // divisor 3 at x16: 64 clocks a bit
  task automatic tx(input logic [13:0] f, input logic [3:0] n);
    @(posedge clk_sys);
    frame <= f;
    count <= n;
    send <= 1'b1;
    @(posedge clk_sys);
    send <= 1'b0;
    repeat (n * 64 + 64) @(posedge clk_sys);
  endtask
  task automatic stop_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (wake_request === 1'b1) wakes <= wakes + 1;
  initial begin
    repeat (60000) @(posedge clk_sys);
    failures++;
    stop_test();
  end
  initial begin
    sys_rst = 1'b1;
    {reg_wr, reg_rd, reg_addr, reg_wdata, sleep_mode, send, inv} = 16'h0000;
    {frame, count, failures, checks, wakes} = 0;
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rdc("status", ADDR_RCV_STAT, 8'h00);
    rdc("baud", ADDR_BAUD_CTRL, 8'h40);
    wr(3'h7, 8'hFF);
    rdc("unmapped", 3'h7, 8'h00);
    wr(ADDR_DIV_LO, 8'h03);
    rdc("divisor", ADDR_DIV_LO, 8'h03);
    wr(ADDR_TX_STAT, 8'h04);
    wr(ADDR_IRQ_CTRL, 8'h07);
    wr(ADDR_RCV_STAT, 8'h90);
    tx({1'b1, 8'hA5, 1'b0}, 10);
    check("irq_high", {7'h0, irq_high}, 8'h01);
    rdc("status", ADDR_RCV_STAT, 8'h90);
    rdc("data", ADDR_RCV_DATA, 8'hA5);
    rdc("irq_ctrl", ADDR_IRQ_CTRL, 8'h07);
    check("irq_high", {7'h0, irq_high}, 8'h00);
    wr(ADDR_RCV_STAT, 8'h80);
    wr(ADDR_BAUD_CTRL, 8'h20);
    inv <= 1'b1;
    wr(ADDR_RCV_STAT, 8'h90);
    tx({1'b1, 8'h3C, 1'b0}, 10);
    rdc("inverted", ADDR_RCV_DATA, 8'h3C);
    wr(ADDR_RCV_STAT, 8'h80);
    wr(ADDR_BAUD_CTRL, 8'h00);
    inv <= 1'b0;
    wr(ADDR_RCV_STAT, 8'hD8);
    tx({1'b1, 9'h055, 1'b0}, 11);
    check("irq_high", {7'h0, irq_high}, 8'h00);
    tx({1'b1, 9'h1C3, 1'b0}, 11);
    rdc("status", ADDR_RCV_STAT, 8'hD9);
    rdc("address", ADDR_RCV_DATA, 8'hC3);
    wr(ADDR_RCV_STAT, 8'hD0);
    tx({1'b1, 9'h07E, 1'b0}, 11);
    rdc("status", ADDR_RCV_STAT, 8'hD0);
    rdc("data", ADDR_RCV_DATA, 8'h7E);
    wr(ADDR_RCV_STAT, 8'h90);
    tx({1'b0, 8'h5A, 1'b0}, 10);
    rdc("status", ADDR_RCV_STAT, 8'h94);
    rdc("data", ADDR_RCV_DATA, 8'h5A);
    wr(ADDR_RCV_STAT, 8'h80);
    wr(ADDR_RCV_STAT, 8'h90);
    rdc("status", ADDR_RCV_STAT, 8'h90);
    tx({1'b1, 8'h11, 1'b0}, 10);
    tx({1'b1, 8'h22, 1'b0}, 10);
    rdc("status", ADDR_RCV_STAT, 8'h92);
    rdc("data", ADDR_RCV_DATA, 8'h11);
    tx({1'b1, 8'h33, 1'b0}, 10);
    check("irq_high", {7'h0, irq_high}, 8'h00);
    wr(ADDR_RCV_STAT, 8'h80);
    rdc("status", ADDR_RCV_STAT, 8'h80);
    tx({1'b1, 8'h44, 1'b0}, 10);
    check("irq_high", {7'h0, irq_high}, 8'h00);
    wr(ADDR_TX_STAT, 8'h14);
    wr(ADDR_RCV_STAT, 8'h90);
    tx({1'b1, 8'h44, 1'b0}, 10);
    check("irq_high", {7'h0, irq_high}, 8'h00);
    wr(ADDR_TX_STAT, 8'h04);
    wr(ADDR_IRQ_CTRL, 8'h03);
    tx({1'b1, 8'h66, 1'b0}, 10);
    check("irq_low", {6'h0, irq_high, irq_low}, 8'h01);
    wr(ADDR_IRQ_CTRL, 8'h01);
    rdc("irq_ctrl", ADDR_IRQ_CTRL, 8'h09);
    check("irq_low", {7'h0, irq_low}, 8'h00);
    rdc("data", ADDR_RCV_DATA, 8'h66);
    wr(ADDR_DIV_LO, 8'h00);
    wr(ADDR_TX_STAT, 8'h00);
    tx({1'b1, 8'h9C, 1'b0}, 10);
    rdc("x64 data", ADDR_RCV_DATA, 8'h9C);
    wr(ADDR_IRQ_CTRL, 8'h07);
    sleep_mode <= 1'b1;
    tx({1'b1, 8'h77, 1'b0}, 10);
    check("irq_high", {7'h0, irq_high}, 8'h00);
    wr(ADDR_BAUD_CTRL, 8'h02);
    tx({1'b1, 12'h000, 1'b0}, 14);
    check("wakes", wakes[7:0], 8'h01);
    check("irq_high", {7'h0, irq_high}, 8'h01);
    sleep_mode <= 1'b0;
    rdc("baud", ADDR_BAUD_CTRL, 8'h40);
    rdc("", ADDR_RCV_DATA, 8'h00);
    rdc("irq_ctrl", ADDR_IRQ_CTRL, 8'h07);
    stop_test();
  end
endmodule
